// *** core/cofc_freeze.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cofc_map.svh"

module cofc_freeze
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic freeze_serial_in,
	input wire logic freeze_shift_clock_in,
	input wire logic freeze_all_strobe_n_in,
	input wire logic common_freeze_level_in,
	input wire logic [`COFC_NUM_OUT-1:0] source_clock_in,
	output logic [`COFC_NUM_OUT-1:0] gated_clock_out,
	output logic [`COFC_NUM_OUT-1:0] output_running_out
);
	import cofc_pkg::*;

	// ****************************************************************
	// State.
	// ****************************************************************
	logic [`COFC_SYNC_W-1:0] sync1_reg, sync1_next;
	logic [`COFC_SYNC_W-1:0] sync2_reg, sync2_next;
	logic sclk_prev_reg, sclk_prev_next;
	logic strobe_prev_reg, strobe_prev_next;
	cofc_state_t state_reg, state_next;
	logic [`COFC_CNT_W-1:0] cnt_reg, cnt_next;
	logic [`COFC_MASK_BITS-1:0] shift_reg, shift_next;
	logic [`COFC_MASK_BITS-1:0] output_freeze_mask_reg, output_freeze_mask_next;
	logic [`COFC_NUM_OUT-1:0] want_reg, want_next;
	logic [`COFC_NUM_OUT-1:0] en_reg, en_next;
	logic [`COFC_NUM_OUT-1:0] gated_reg, gated_next;

	logic [`COFC_NUM_OUT-1:0] src_s;
	logic data_s;
	logic shift_rise;
	logic strobe_ev;
	logic level_s;
	logic load_ev;
	logic [`COFC_MASK_BITS-1:0] load_word;

	assign src_s = sync2_reg[`COFC_NUM_OUT-1:0];
	assign data_s = sync2_reg[`COFC_SYNC_DATA];
	assign level_s = sync2_reg[`COFC_SYNC_LEVEL];
	assign shift_rise = sync2_reg[`COFC_SYNC_SCLK] & ~sclk_prev_reg;
	assign strobe_ev = ~sync2_reg[`COFC_SYNC_STROBE] & strobe_prev_reg;
	assign load_ev = (state_reg == COFC_SHIFT) && shift_rise && (cnt_reg == `COFC_LAST_BIT);
	assign load_word = shift_reg | ({{(`COFC_MASK_BITS-1){1'b0}}, data_s} << cnt_reg);

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	always_comb
	begin
		sync1_next = {freeze_all_strobe_n_in, common_freeze_level_in, freeze_serial_in,
			freeze_shift_clock_in, source_clock_in};
		sync2_next = sync1_reg;
		sclk_prev_next = sync2_reg[`COFC_SYNC_SCLK];
		strobe_prev_next = sync2_reg[`COFC_SYNC_STROBE];
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		output_freeze_mask_next = output_freeze_mask_reg;
		want_next = want_reg;

		// Serial receiver, bit 0 first, sampled on the shift clock rising edge.
		if (shift_rise)
		begin
			case (state_reg)
				COFC_IDLE:
				begin
					if (data_s == `COFC_START_BIT)
					begin
						state_next = COFC_SHIFT;
						cnt_next = `COFC_CNT_RST;
						shift_next = {`COFC_MASK_BITS{1'b0}};
					end
				end
				COFC_SHIFT:
				begin
					shift_next = load_word;
					cnt_next = cnt_reg + 4'h1;
					if (load_ev)
					begin
						state_next = COFC_IDLE;
						output_freeze_mask_next = load_word;
					end
				end
				default:
				begin
					state_next = COFC_IDLE;
				end
			endcase
		end

		// A new mask touches only the 13 masked outputs; the strobe wins a tie.
		if (load_ev)
		begin
			want_next[`COFC_MASK_BITS-1:0] = load_word;
		end
		if (strobe_ev)
		begin
			want_next = level_s ? `COFC_ALL_RUN : `COFC_ALL_FROZEN;
		end

		// Enables only change while the source clock is low, so the gated
		// clock never loses the tail of a high phase nor gains a runt.
		for (int i = 0; i < `COFC_NUM_OUT; i++)
		begin
			en_next[i] = src_s[i] ? en_reg[i] : want_reg[i];
			gated_next[i] = src_s[i] & en_next[i];
		end
	end

	// ****************************************************************
	// Registers.
	// ****************************************************************
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sync1_reg <= `COFC_SYNC_RST;
			sync2_reg <= `COFC_SYNC_RST;
			sclk_prev_reg <= 1'h1;
			strobe_prev_reg <= 1'h1;
			state_reg <= COFC_IDLE;
			cnt_reg <= `COFC_CNT_RST;
			shift_reg <= `COFC_MASK_RST;
			output_freeze_mask_reg <= `COFC_MASK_RST;
			want_reg <= `COFC_ALL_RUN;
			en_reg <= `COFC_ALL_RUN;
			gated_reg <= `COFC_ALL_FROZEN;
		end
		else
		begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sclk_prev_reg <= sclk_prev_next;
			strobe_prev_reg <= strobe_prev_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			output_freeze_mask_reg <= output_freeze_mask_next;
			want_reg <= want_next;
			en_reg <= en_next;
			gated_reg <= gated_next;
		end
	end

	assign gated_clock_out = gated_reg;
	assign output_running_out = en_reg;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	sequence start_seq;
		(state_reg == COFC_IDLE) && shift_rise && !data_s;
	endsequence

	sequence last_bit_seq;
		(state_reg == COFC_SHIFT) && shift_rise && (cnt_reg == `COFC_LAST_BIT);
	endsequence

	sequence freeze_all_seq;
		strobe_ev && !level_s;
	endsequence

	sequence run_all_seq;
		strobe_ev && level_s;
	endsequence

	frozen_stays_low_a: assert property ((gated_reg & ~en_reg) == `COFC_ALL_FROZEN)
		else $error("Frozen output is high.");

	enable_in_low_a: assert property (((en_reg ^ $past(en_reg)) & $past(src_s)) == `COFC_ALL_FROZEN)
		else $error("Enable changed while source clock high.");

	freeze_all_a: assert property (freeze_all_seq |=> want_reg == `COFC_ALL_FROZEN ##1 (en_reg & ~$past(src_s)) == `COFC_ALL_FROZEN)
		else $error("Freeze-all strobe did not freeze every output.");

	unfreeze_all_a: assert property (run_all_seq |=> want_reg == `COFC_ALL_RUN)
		else $error("Unfreeze-all strobe did not release every output.");

	// An unfreeze-all releases every output while the stored mask keeps its last loaded value.
	strobe_overrides_a: assert property (run_all_seq ##0 !load_ev |=>
		(want_reg == `COFC_ALL_RUN) && (output_freeze_mask_reg == $past(output_freeze_mask_reg)))
		else $error("Strobe altered the loaded mask.");

	unmasked_kept_a: assert property (load_ev && !strobe_ev |=>
		want_reg[`COFC_NUM_OUT-1:`COFC_UNMASKED_LSB] == $past(want_reg[`COFC_NUM_OUT-1:`COFC_UNMASKED_LSB]))
		else $error("Serial load touched an unmasked output.");

	mask_load_a: assert property (last_bit_seq ##0 !strobe_ev |=>
		(output_freeze_mask_reg == $past(load_word)) && (want_reg[`COFC_MASK_BITS-1:0] == $past(load_word)))
		else $error("Mask not taken from the 13 received bits.");

	start_bit_a: assert property (start_seq |=> (state_reg == COFC_SHIFT) && (cnt_reg == `COFC_CNT_RST))
		else $error("Low start bit did not open a frame.");

	frame_end_a: assert property (last_bit_seq |=> state_reg == COFC_IDLE)
		else $error("Frame did not close after the 13th bit.");

	mask_hold_a: assert property ((state_reg == COFC_SHIFT) && !load_ev |=>
		output_freeze_mask_reg == $past(output_freeze_mask_reg))
		else $error("Mask changed before the frame completed.");

	idle_ignores_high_a: assert property ((state_reg == COFC_IDLE) && shift_rise && data_s |=> state_reg == COFC_IDLE)
		else $error("High data bit opened a frame.");

	no_forced_high_a: assert property ((gated_reg & ~$past(src_s)) == `COFC_ALL_FROZEN)
		else $error("Gated output high without its source clock.");

	reset_state_a: assert property (disable iff (1'b0) !rst_n_in |=>
		(want_reg == `COFC_ALL_RUN) && (output_freeze_mask_reg == `COFC_MASK_RST))
		else $error("Reset did not leave every output unfrozen.");

endmodule

`default_nettype wire

// *** core/cofc_map.svh ***
// What this block does
// - A 13-bit freeze mask holds one enable bit for each of 13 of the 15 clock outputs.
// - The two zero-numbered bus and peripheral bus clocks have no mask bit and the serial port never stops them.
// - A mask bit loaded as zero freezes its output and a mask bit loaded as one lets it run.
// - A frozen output is held low for as long as it stays frozen.
// - A low-going strobe pulse with the common level low freezes all fifteen outputs together.
// - A low-going strobe pulse with the common level high unfreezes all fifteen outputs together.
// - A freeze never pulls an output low early; it waits for the natural low and then holds it.
// - An unfreeze re-enables an output only while its source clock is low, so no short high pulse appears.
// - A serial load is one low start bit followed by 13 NRZ mask bits.
// - Each serial bit lasts one shift clock period and is sampled on the shift clock rising edge.
// - Mask bits 0, 1 and 2 gate the double rate, cpu qualifier and bus qualifier clocks, bits 3-6 bus clocks 1-4, bits 7-12 peripheral clocks 1-6.
// - An unfreeze-all strobe restarts outputs the mask had frozen without reloading the mask.
`ifndef COFC_MAP_SVH
`define COFC_MAP_SVH

// Output index: 0 double rate cpu, 1 cpu qualifier, 2 bus qualifier, 3-6 bus 1-4,
// 7-12 peripheral 1-6, 13 bus clock zero, 14 peripheral bus clock zero.
`define COFC_NUM_OUT 15
`define COFC_MASK_BITS 13
`define COFC_UNMASKED_LSB 13
`define COFC_CNT_W 4
`define COFC_LAST_BIT 4'hC
`define COFC_CNT_RST 4'h0
`define COFC_MASK_RST 13'h1FFF
`define COFC_ALL_RUN 15'h7FFF
`define COFC_ALL_FROZEN 15'h0000
`define COFC_SYNC_W 19
`define COFC_SYNC_RST 19'h7FFFF
`define COFC_SYNC_STROBE 18
`define COFC_SYNC_LEVEL 17
`define COFC_SYNC_DATA 16
`define COFC_SYNC_SCLK 15
`define COFC_START_BIT 1'h0

`endif

// *** core/cofc_pad.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** core/cofc_pkg.sv ***
`default_nettype none
package cofc_pkg;
	typedef enum logic {COFC_IDLE, COFC_SHIFT} cofc_state_t;
endpackage
`default_nettype wire

// *** testbench/clock_output_freeze_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module clock_output_freeze_control_tb;
	logic mclk = 1'b0;
	logic rst_n;
	logic [14:0] src;
	logic [4:0] phase = 5'h00;
	wire logic ser;
	wire logic sclk;
	wire logic stb_n;
	wire logic lvl;
	wire logic [14:0] gated;
	wire logic [14:0] running;
	int err_total = 0;
	int cmp_count = 0;
	always #4 mclk = ~mclk;
	// Source clocks run at 1/16 of mclk, alternate outputs in opposite phase.
	always @(negedge mclk)
	begin
		phase <= phase + 5'h01;
		src <= {15{phase[3]}} ^ 15'h5555;
	end
	cofc_ctrl_model u_ctrl (.mclk_in(mclk), .freeze_serial_out(ser), .freeze_shift_clock_out(sclk),
		.freeze_all_strobe_n_out(stb_n), .common_freeze_level_out(lvl));
	cofc_freeze uut (.mclk_in(mclk), .rst_n_in(rst_n), .freeze_serial_in(ser), .freeze_shift_clock_in(sclk),
		.freeze_all_strobe_n_in(stb_n), .common_freeze_level_in(lvl), .source_clock_in(src),
		.gated_clock_out(gated), .output_running_out(running));
	task check_state(input logic [14:0] exp);
		logic [14:0] seen;
		seen = 15'h0000;
		repeat (48) @(negedge mclk);
		cmp_count++;
		if (running !== exp)
		begin
			$display("MISMATCH t=%0t running %h expected %h", $time, running, exp);
			err_total++;
		end
		repeat (40)
		begin
			@(negedge mclk);
			seen = seen | gated;
		end
		cmp_count++;
		if (seen !== exp)
		begin
			$display("MISMATCH t=%0t active outputs %h expected %h", $time, seen, exp);
			err_total++;
		end
		$display("test done, expected outputs %h", exp);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// A hung run counts as a failure and still reaches the verdict.
	initial
	begin
		repeat (20000) @(posedge mclk);
		$display("MISMATCH t=%0t watchdog expired", $time);
		err_total++;
		give_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		check_state(15'h7FFF);
		u_ctrl.send_mask(13'h1555);
		check_state(15'h7555);
		u_ctrl.send_mask(13'h0000);
		check_state(15'h6000);
		u_ctrl.pulse(1'b1);
		check_state(15'h7FFF);
		u_ctrl.pulse(1'b0);
		check_state(15'h0000);
		u_ctrl.send_mask(13'h1FFF);
		check_state(15'h1FFF);
		u_ctrl.send_mask(13'h0001);
		check_state(15'h0001);
		u_ctrl.pulse(1'b1);
		check_state(15'h7FFF);
		u_ctrl.send_mask(13'h0AAA);
		check_state(15'h6AAA);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		check_state(15'h7FFF);
		give_verdict();
	end
endmodule
`default_nettype wire

// *** testbench/cofc_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cofc_ctrl_model
(
	input wire logic mclk_in,
	output logic freeze_serial_out,
	output logic freeze_shift_clock_out,
	output logic freeze_all_strobe_n_out,
	output logic common_freeze_level_out
);
	initial
	begin
		freeze_serial_out = 1'b1;
		freeze_shift_clock_out = 1'b0;
		freeze_all_strobe_n_out = 1'b1;
		common_freeze_level_out = 1'b1;
	end
	// The shift clock runs free; bits change on its falling edge.
	always #80 freeze_shift_clock_out = ~freeze_shift_clock_out;
	task send_mask(input logic [12:0] mask);
		@(negedge freeze_shift_clock_out);
		freeze_serial_out = 1'b0;
		for (int i = 0; i < 13; i++)
		begin
			@(negedge freeze_shift_clock_out);
			freeze_serial_out = mask[i];
		end
		@(negedge freeze_shift_clock_out);
		freeze_serial_out = 1'b1;
	endtask
	task pulse(input logic level);
		@(negedge mclk_in);
		common_freeze_level_out = level;
		repeat (4) @(negedge mclk_in);
		freeze_all_strobe_n_out = 1'b0;
		repeat (4) @(negedge mclk_in);
		freeze_all_strobe_n_out = 1'b1;
	endtask
endmodule
`default_nettype wire
